// File: verilog/uhped_port_detect.sv
// USB host downstream port event detector with APB register access
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module uhped_port_detect
   import uhped_pkg::*;
#(
   parameter int CHIRP_MIN = CHIRP_MIN_CYC,
   parameter int CHIRP_END = CHIRP_END_CYC,
   parameter int WAKE_HOLD = WAKE_HOLD_CYC,
   parameter int RESUME    = RESUME_CYC
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Transceiver line and frame engine
   input  wire logic [1:0]  line_condition,
   input  wire logic        frame_boundary,
   input  wire logic        rx_eop_pending,
   // Port drive and transaction control
   output uhped_xcvr_t      xcvr,
   output logic             transceiver_macro_reset,
   output logic             transaction_enable
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   localparam int MAX_CNT = (1 << TIMER_W) - 1;
   if (CHIRP_END > MAX_CNT || RESUME > MAX_CNT || WAKE_HOLD > MAX_CNT ||
       CHIRP_MIN > MAX_CNT || CHIRP_MIN < 1 || WAKE_HOLD < 1 || RESUME < 1 ||
       CHIRP_MIN >= CHIRP_END) begin : g_chk
      $error("uhped_port_detect: timing parameter out of counter range");
   end

   localparam logic [TIMER_W-1:0] K_LIM    = TIMER_W'(K_FILT_CYC);
   localparam logic [TIMER_W-1:0] MIN_LIM  = TIMER_W'(CHIRP_MIN);
   localparam logic [TIMER_W-1:0] END_LIM  = TIMER_W'(CHIRP_END);
   localparam logic [TIMER_W-1:0] HOLD_LIM = TIMER_W'(WAKE_HOLD);
   localparam logic [TIMER_W-1:0] RES_LIM  = TIMER_W'(RESUME);
   localparam logic [2:0]         ABT_LAST = 3'(ABORT_CYC - 1);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   uhped_state_t         state;
   uhped_state_t         next_state;
   logic [TIMER_W-1:0]   k_count;
   logic [TIMER_W-1:0]   last_k;
   logic [TIMER_W-1:0]   state_time;
   logic                 wakeup_accept_enable;
   logic                 wake_det_en;
   logic                 chirp_armed;
   logic                 chirp_seen;
   logic                 fault_halt;
   logic                 abort_busy;
   logic [2:0]           abort_cnt;
   logic [FLAG_W-1:0]    flags;
   logic [FLAG_W-1:0]    flag_set;
   logic                 wr_en;
   logic                 wr_ctrl_a;
   logic                 cmd_take;
   logic                 abort_take;
   logic [CMD_W-1:0]     cmd_code;
   logic                 line_k;
   logic                 chirp_ok;
   logic                 chirp_ng;

   assign line_k = (line_condition == LINE_K);

   // ----------------------------------------------------------------
   // APB decode; zero wait states
   // ----------------------------------------------------------------
   assign pready     = 1'b1;
   assign wr_en      = psel && penable && pwrite;
   assign wr_ctrl_a  = wr_en && (paddr == REG_CTRL_A);
   assign cmd_code   = pwdata[CMD_LSB +: CMD_W];
   // An abort write carries the cancel bit and a zero command
   assign abort_take = wr_ctrl_a && pwdata[ABORT_BIT] && (cmd_code == cmd_none);
   // Commands are ignored while an abort is still running
   assign cmd_take   = wr_ctrl_a && !pwdata[ABORT_BIT] && (cmd_code != cmd_none) && !abort_busy;

   // Unmapped addresses answer with an error and read as zero
   always_comb begin
      pslverr = 1'b0;
      if (psel && penable) begin
         pslverr = !(paddr == REG_CTRL_A || paddr == REG_CTRL_B ||
                     paddr == REG_STATUS || paddr == REG_XCVR);
      end
   end

   // Read data is held in a flop and loaded in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable) begin
         prdata <= '0;
         unique case (paddr)
            REG_CTRL_A: begin
               prdata[ABORT_BIT]                <= abort_busy;
               prdata[STATE_LSB +: 3]           <= state;
               prdata[MACRO_RST_BIT]            <= transceiver_macro_reset;
            end
            REG_CTRL_B: prdata[WAKE_EN_BIT]     <= wakeup_accept_enable;
            REG_STATUS: prdata[FLAG_W-1:0]      <= flags;
            REG_XCVR:   prdata[$bits(uhped_xcvr_t)-1:0] <= xcvr;
            default:    prdata <= '0;
         endcase
      end
   end

   // Software-owned control bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wakeup_accept_enable    <= 1'b0;
         transceiver_macro_reset <= 1'b0;
      end else begin
         if (wr_en && paddr == REG_CTRL_B) begin
            wakeup_accept_enable <= pwdata[WAKE_EN_BIT];
         end
         // Firmware keeps this high for at least three cycles
         if (wr_ctrl_a) begin
            transceiver_macro_reset <= pwdata[MACRO_RST_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Abort sequence: cancel bit self-clears after a fixed count
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_busy <= 1'b0;
         abort_cnt  <= '0;
      end else if (abort_take && !abort_busy) begin
         abort_busy <= 1'b1;
         abort_cnt  <= '0;
      end else if (abort_busy) begin
         abort_cnt <= abort_cnt + 1'b1;
         if (abort_cnt == ABT_LAST) begin
            abort_busy <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Host state
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      if (cmd_take) begin
         unique case (cmd_code)
            cmd_go_idle:      next_state = st_idle;
            cmd_disable_port: next_state = st_disabled;
            cmd_bus_reset:    next_state = st_reset;
            cmd_operational:  next_state = st_operational;
            cmd_suspend:      next_state = st_suspend;
            cmd_resume:       next_state = st_resume;
            default:          next_state = state;
         endcase
      end else if (state == st_resume && state_time >= RES_LIM) begin
         next_state = st_operational;
      end
   end

   // Port drive follows the state at the same edge, so idle acts at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= st_idle;
         xcvr  <= XCVR_RST;
      end else begin
         state <= next_state;
         xcvr  <= uhped_xcvr_of(next_state);
      end
   end

   // ----------------------------------------------------------------
   // Duration counters, all in pclk cycles
   // ----------------------------------------------------------------
   // Counts continuous K on the sampled line, at any port speed
   uhped_run_timer #(.W(TIMER_W)) u_k_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (!line_k),
      .count   (k_count)
   );

   // Counts time since the last accepted command; not restarted when resume passes to operational
   uhped_run_timer #(.W(TIMER_W)) u_state_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (cmd_take),
      .count   (state_time)
   );

   // Keeps the length of the latest K run for the chirp-end check
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_k <= '0;
      end else if (line_k) begin
         last_k <= k_count;
      end
   end

   // ----------------------------------------------------------------
   // Remote wakeup detection
   // ----------------------------------------------------------------
   // Disabled on entry to suspend, re-enabled after the hold if allowed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_det_en <= 1'b0;
      end else if (next_state != st_suspend || cmd_take || abort_busy) begin
         wake_det_en <= 1'b0;
      end else if (state_time >= HOLD_LIM) begin
         wake_det_en <= wakeup_accept_enable;
      end
   end

   // ----------------------------------------------------------------
   // Device chirp detection
   // ----------------------------------------------------------------
   // Passes once the K run ends in SE0 inside the window
   assign chirp_ok = chirp_armed && chirp_seen && (line_condition == LINE_SE0) &&
                     (last_k >= MIN_LIM) && (state_time < END_LIM);
   // Fails when the window closes with the chirp still going
   assign chirp_ng = chirp_armed && chirp_seen && !chirp_ok && (state_time >= END_LIM);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chirp_armed <= 1'b0;
         chirp_seen  <= 1'b0;
      end else if (cmd_take) begin
         chirp_armed <= (next_state == st_reset);
         chirp_seen  <= 1'b0;
      end else if (abort_busy || state != st_reset || chirp_ok || chirp_ng) begin
         chirp_armed <= 1'b0;
         chirp_seen  <= 1'b0;
      end else if (chirp_armed) begin
         if (k_count == K_LIM) begin
            chirp_seen <= 1'b1;
         end else if (line_condition == LINE_SE0) begin
            chirp_seen <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Port error detection and transaction gating
   // ----------------------------------------------------------------
   // The halt stays until firmware issues a fresh state command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_halt <= 1'b0;
      end else if (cmd_take) begin
         fault_halt <= 1'b0;
      end else if (flag_set[ST_FAULT_BIT]) begin
         fault_halt <= 1'b1;
      end
   end

   // Registered so the halt shows at the same edge as the fault flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transaction_enable <= 1'b0;
      end else begin
         transaction_enable <= (next_state == st_operational) && !cmd_take && !abort_busy &&
                               !fault_halt && !flag_set[ST_FAULT_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Status flags: set wins over a write-one clear
   // ----------------------------------------------------------------
   always_comb begin
      flag_set               = '0;
      flag_set[ST_WAKE_BIT]  = wake_det_en && (k_count == K_LIM);
      flag_set[ST_GOOD_BIT]  = chirp_ok;
      flag_set[ST_FAIL_BIT]  = chirp_ng;
      flag_set[ST_FAULT_BIT] = (state == st_operational) && !fault_halt &&
                               frame_boundary && rx_eop_pending;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= '0;
      end else if (wr_en && paddr == REG_STATUS) begin
         flags <= (flags & ~pwdata[FLAG_W-1:0]) | flag_set;
      end else begin
         flags <= flags | flag_set;
      end
   end

   // ----------------------------------------------------------------
   // Assertions and covers
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_wake_gate_state: assert property ($rose(flags[ST_WAKE_BIT]) |->
      $past(state) == st_suspend && $past(wakeup_accept_enable))
      else $error("wake outside suspend");
   // The run may end in the very cycle the count reaches the limit, so look one further back
   a_wake_k_length: assert property ($rose(flags[ST_WAKE_BIT]) |->
      $past(k_count) == K_LIM && $past(line_k, 2)) else $error("wake flag at wrong K length");
   a_resume_drive_start: assert property (cmd_take && cmd_code == cmd_resume |->
      ##1 xcvr.drive_resume_k && state == st_resume) else $error("resume K not driven");
   a_chirp_in_reset: assert property ($rose(flags[ST_GOOD_BIT] | flags[ST_FAIL_BIT]) |->
      $past(state) == st_reset) else $error("chirp status outside reset");
   a_chirp_good_window: assert property ($rose(flags[ST_GOOD_BIT]) |->
      $past(last_k) >= MIN_LIM && $past(state_time) < END_LIM)
      else $error("chirp-good out of window");
   a_chirp_fail_time: assert property ($rose(flags[ST_FAIL_BIT]) |->
      $past(state_time) >= END_LIM) else $error("chirp-failed too early");
   a_chirp_disarm: assert property ((chirp_ok || chirp_ng) && !cmd_take |=>
      !chirp_armed [*2]) else $error("chirp detection still on");
   a_fault_halts: assert property (flag_set[ST_FAULT_BIT] |=>
      flags[ST_FAULT_BIT] && !transaction_enable) else $error("fault did not halt");
   a_abort_self_clear: assert property ($rose(abort_busy) |->
      abort_busy [*6] ##1 !abort_busy) else $error("cancel bit timing wrong");
   a_idle_quiet: assert property (state == st_idle |-> !xcvr.bus_power_enable &&
      xcvr.transceiver_operating_mode == undriven_mode && !transaction_enable &&
      !wake_det_en && !chirp_armed) else $error("idle not quiet");

   c_wakeup_seen: cover property ($rose(flags[ST_WAKE_BIT]));
   c_chirp_good:  cover property ($rose(flags[ST_GOOD_BIT]));
   c_chirp_fail:  cover property ($rose(flags[ST_FAIL_BIT]));
   c_port_fault:  cover property ($rose(flags[ST_FAULT_BIT]));
   c_abort_idle:  cover property ($fell(abort_busy) ##[1:20] state == st_idle);

endmodule

// File: verilog/uhped_pkg.sv
// Constants, codes and carrier types for the host port event detector
package uhped_pkg;

   // ----------------------------------------------------------------
   // Timing, given in ns or us and converted to pclk cycles, except the abort length given in cycles
   // ----------------------------------------------------------------
   localparam int CLK_MHZ        = 40;
   localparam int K_FILT_NS      = 2500;   // K must be held longer than this
   localparam int K_FILT_CYC     = (K_FILT_NS * CLK_MHZ) / 1000 + 1;
   localparam int CHIRP_MIN_US   = 1000;   // Least chirp length
   localparam int CHIRP_MIN_CYC  = CHIRP_MIN_US * CLK_MHZ;
   localparam int CHIRP_END_US   = 7000;   // Chirp must end before this after reset
   localparam int CHIRP_END_CYC  = CHIRP_END_US * CLK_MHZ;
   localparam int WAKE_HOLD_US   = 100;    // Detection off after entering suspend
   localparam int WAKE_HOLD_CYC  = WAKE_HOLD_US * CLK_MHZ;
   localparam int RESUME_US      = 20000;  // Length of driven resume K
   localparam int RESUME_CYC     = RESUME_US * CLK_MHZ;
   localparam int ABORT_CYC      = 6;      // Cycles taken by an abort
   localparam int TIMER_W        = 20;

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL_A  = 8'h00;  // host_negotiation_control_a
   localparam logic [7:0] REG_CTRL_B  = 8'h04;  // host_negotiation_control_b
   localparam logic [7:0] REG_STATUS  = 8'h08;  // host_engine_status_a
   localparam logic [7:0] REG_XCVR    = 8'h0c;  // host_transceiver_control
   localparam int CMD_LSB       = 0;
   localparam int CMD_W         = 4;
   localparam int ABORT_BIT     = 7;
   localparam int STATE_LSB     = 8;
   localparam int MACRO_RST_BIT = 12;
   localparam int WAKE_EN_BIT   = 0;
   localparam int ST_WAKE_BIT   = 0;
   localparam int ST_GOOD_BIT   = 1;
   localparam int ST_FAIL_BIT   = 2;
   localparam int ST_FAULT_BIT  = 3;
   localparam int FLAG_W        = 4;

   // ----------------------------------------------------------------
   // Codes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      cmd_none         = 4'h0,
      cmd_go_idle      = 4'h1,
      cmd_disable_port = 4'h3,
      cmd_bus_reset    = 4'h4,
      cmd_operational  = 4'h5,
      cmd_suspend      = 4'h6,
      cmd_resume       = 4'h7
   } uhped_cmd_t;

   typedef enum logic [2:0] {
      st_idle        = 3'b000,
      st_disabled    = 3'b001,
      st_reset       = 3'b010,
      st_operational = 3'b011,
      st_suspend     = 3'b100,
      st_resume      = 3'b101
   } uhped_state_t;

   localparam logic [1:0] LINE_SE0       = 2'b00;
   localparam logic [1:0] LINE_K         = 2'b10;
   localparam logic [1:0] SPEED_HS       = 2'b00;
   localparam logic [1:0] SPEED_FS       = 2'b01;
   localparam logic [1:0] MODE_NORMAL    = 2'b00;
   localparam logic [1:0] undriven_mode  = 2'b01;
   localparam logic [1:0] MODE_POWERDOWN = 2'b10;

   // Transceiver and port drive settings, carried together
   typedef struct packed {
      logic       bus_power_enable;
      logic [1:0] transceiver_speed_select;
      logic       termination_select;       // 1: full-speed termination
      logic [1:0] transceiver_operating_mode;
      logic       drive_resume_k;
      logic       drive_reset_se0;
   } uhped_xcvr_t;

   localparam uhped_xcvr_t XCVR_RST = '{1'b0, SPEED_FS, 1'b1, undriven_mode, 1'b0, 1'b0};

   // Port drive settings that belong to each host state
   function automatic uhped_xcvr_t uhped_xcvr_of(input uhped_state_t st);
      uhped_xcvr_t x;
      x = XCVR_RST;
      unique case (st)
         st_idle:        x = XCVR_RST;
         st_disabled:    x = '{1'b1, SPEED_FS, 1'b1, MODE_POWERDOWN, 1'b0, 1'b0};
         st_reset:       x = '{1'b1, SPEED_HS, 1'b0, MODE_NORMAL, 1'b0, 1'b1};
         st_operational: x = '{1'b1, SPEED_FS, 1'b1, MODE_NORMAL, 1'b0, 1'b0};
         st_suspend:     x = '{1'b1, SPEED_FS, 1'b1, MODE_POWERDOWN, 1'b0, 1'b0};
         st_resume:      x = '{1'b1, SPEED_FS, 1'b1, MODE_NORMAL, 1'b1, 1'b0};
         default:        x = XCVR_RST;
      endcase
      return x;
   endfunction

endpackage

// File: verilog/uhped_run_timer.sv
// Saturating cycle counter that restarts on a clear
`timescale 1ns/10ps
module uhped_run_timer #(
   parameter int W = 20
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Control
   input  wire logic         clear,
   // Count of cycles since the last clear
   output logic [W-1:0]      count
);

   // Saturates instead of wrapping so a long wait never looks short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
      end else if (clear) begin
         count <= '0;
      end else if (count != {W{1'b1}}) begin
         count <= count + 1'b1;
      end
   end

endmodule

// File: sim/uhped_peripheral.sv
// Behavioural attached peripheral that drives K runs onto the line
`timescale 1ns/10ps
module uhped_peripheral
   import uhped_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Run request from the bench
   input  wire logic        go,
   input  wire logic [15:0] k_len,
   input  wire logic [1:0]  rest,
   // Line state seen by the host port
   output logic [1:0]       line_condition
);
   logic [15:0] left;
   // K run length; the line returns to the bus resting level, never holds K
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left <= 16'h0;
      end else if (go) begin
         left <= k_len;
      end else if (left != 16'h0) begin
         left <= left - 16'h1;
      end
   end
   assign line_condition = (left != 16'h0) ? LINE_K : rest;
endmodule

// File: sim/test_usb_host_port_event_detect.sv
// Self-checking bench for the host port event detector
`timescale 1ns/10ps
module test_usb_host_port_event_detect
   import uhped_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, go;
   logic        frame_boundary, rx_eop_pending, transceiver_macro_reset, transaction_enable;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] k_len;
   logic [1:0]  line_condition, rest;
   uhped_xcvr_t xcvr;
   int          n_mismatch = 0;
   int          n_tests = 0;
   // Short counts keep the run brief; expectations follow these values
   uhped_port_detect #(.CHIRP_MIN(400), .CHIRP_END(2800), .WAKE_HOLD(20), .RESUME(50)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .line_condition(line_condition), .frame_boundary(frame_boundary),
      .rx_eop_pending(rx_eop_pending), .xcvr(xcvr),
      .transceiver_macro_reset(transceiver_macro_reset),
      .transaction_enable(transaction_enable));
   uhped_peripheral i_dev (.pclk(pclk), .presetn(presetn), .go(go), .k_len(k_len),
      .rest(rest), .line_condition(line_condition));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Peripheral drives a K run of n cycles, then the resting level r
   task automatic kick(input int n, input logic [1:0] r);
      @(posedge pclk);
      k_len <= 16'(n);
      rest <= r;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      cyc(n + 10);
   endtask
   task automatic status(input logic [31:0] exp);
      apb(1'b0, REG_STATUS, 32'h0);
      chk("status", rd, exp);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      cyc(40000);
      n_mismatch++;
      conclude();
   end
   initial begin
      {presetn, psel, penable, pwrite, go, frame_boundary, rx_eop_pending} = '0;
      paddr = 8'h0;
      pwdata = 32'h0;
      k_len = 16'h0;
      rest = 2'b01;
      cyc(20);
      presetn <= 1'b1;
      apb(1'b0, REG_XCVR, 32'h0);
      chk("xcvr reset", rd, 32'h34);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      $display("test reset done");
      // Wakeup: refused while disabled, short K ignored, long K latched
      apb(1'b1, REG_CTRL_A, 32'h6);
      cyc(30);
      kick(130, 2'b01);
      status(32'h0);
      apb(1'b1, REG_CTRL_B, 32'h1);
      kick(90, 2'b01);
      status(32'h0);
      kick(130, 2'b01);
      cyc(200);
      status(32'h1);
      apb(1'b1, REG_CTRL_A, 32'h7);
      // Port drive is launched at the write edge; look one edge later
      cyc(1);
      chk("resume k", {24'h0, xcvr}, 32'hb2);
      apb(1'b1, REG_STATUS, 32'h1);
      status(32'h0);
      cyc(60);
      $display("test wakeup done");
      // Chirp: short K dropped, good chirp, then detection off
      apb(1'b1, REG_CTRL_A, 32'h4);
      kick(50, 2'b00);
      kick(500, 2'b00);
      status(32'h2);
      apb(1'b1, REG_STATUS, 32'h2);
      kick(500, 2'b00);
      status(32'h0);
      apb(1'b1, REG_CTRL_A, 32'h4);
      kick(3000, 2'b00);
      status(32'h4);
      apb(1'b1, REG_STATUS, 32'h4);
      $display("test chirp done");
      // Fault: open packet at a frame end halts transactions
      apb(1'b1, REG_CTRL_A, 32'h5);
      for (int i = 0; i < 2; i++) begin
         @(posedge pclk);
         rx_eop_pending <= 1'(i);
         frame_boundary <= 1'b1;
         @(posedge pclk);
         frame_boundary <= 1'b0;
         cyc(2);
         chk("txn enable", 32'(transaction_enable), 32'(i == 0));
      end
      rx_eop_pending <= 1'b0;
      status(32'h8);
      apb(1'b1, REG_CTRL_A, 32'h3);
      apb(1'b1, REG_CTRL_A, 32'h1000);
      cyc(1);
      chk("macro reset", 32'(transceiver_macro_reset), 32'h1);
      cyc(3);
      apb(1'b1, REG_CTRL_A, 32'h0);
      cyc(1);
      chk("macro reset", 32'(transceiver_macro_reset), 32'h0);
      apb(1'b1, REG_STATUS, 32'h8);
      $display("test fault done");
      // Abort, wait for cancel to clear, then go idle
      apb(1'b1, REG_CTRL_A, 32'h80);
      apb(1'b0, REG_CTRL_A, 32'h0);
      chk("cancel", 32'(rd[ABORT_BIT]), 32'h1);
      for (int i = 0; i < 20 && rd[ABORT_BIT] !== 1'b0; i++) apb(1'b0, REG_CTRL_A, 32'h0);
      chk("cancel", 32'(rd[ABORT_BIT]), 32'h0);
      apb(1'b1, REG_CTRL_A, 32'h1);
      apb(1'b0, REG_CTRL_A, 32'h0);
      chk("state", 32'(rd[10:8]), 32'h0);
      chk("xcvr idle", {24'h0, xcvr}, 32'h34);
      chk("txn enable", 32'(transaction_enable), 32'h0);
      kick(130, 2'b01);
      status(32'h0);
      $display("test idle done");
      conclude();
   end
endmodule
